// [hdl/core_cfg.svh]
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// ==========================================================
// Reset values
`define PC_RESET 16'h0000
`define SP_RESET 16'h08FF
`define STATUS_FLAGS_REG_RESET 8'h00
`define IR_RESET 16'h0000

// ==========================================================
// Status flag positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ==========================================================
// Pointer pairs (pair index = register number / 2)
`define PAIR_X 4'hD
`define PAIR_Y 4'hE
`define PAIR_Z 4'hF

// ==========================================================
// Instruction word fields
`define F_OP_HI 15
`define F_OP_LO 10
`define F_RD_HI 9
`define F_RD_LO 5
`define F_RR_HI 4
`define F_RR_LO 0
`define F_K_HI 9
`define F_K_LO 3
`define F_S_HI 2
`define F_S_LO 0
`define F_IOB_HI 7
`define F_IOB_LO 5
`define F_IO_HI 4
`define F_IO_LO 0
`define F_PTR_HI 4
`define F_PTR_LO 3
`define F_MODE_HI 1
`define F_MODE_LO 0
`define F_ZSEL 4
`define F_Q_HI 3
`define F_Q_LO 0
`define F_IMM_NIB_HI 15
`define F_IMM_NIB_LO 12
`define F_IMM_RD_HI 11
`define F_IMM_RD_LO 8
`define F_IMM_HI 7
`define F_IMM_LO 0
`define NIB_CMP_IMM 4'hE
`define NIB_LOAD_IMM 4'hF
`define OP_LAST 6'h29

// ==========================================================
// Pointer access modes
`define MODE_PLAIN 2'h0
`define MODE_POST_INC 2'h1
`define MODE_PRE_DEC 2'h2

`endif

// [hdl/core_pkg.sv]
package core_pkg;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_MOV = 6'h01, OP_PAIR = 6'h02, OP_CP = 6'h03, OP_CPC = 6'h04,
    OP_EQSKIP = 6'h05, OP_SKRC = 6'h06, OP_SKRS = 6'h07, OP_SKIC = 6'h08,
    OP_SKIS = 6'h09, OP_BRS = 6'h0A, OP_BRC = 6'h0B, OP_BGE = 6'h0C, OP_BLT = 6'h0D,
    OP_IOSET = 6'h0E, OP_IOCLR = 6'h0F, OP_LSL = 6'h10, OP_LSR = 6'h11,
    OP_ROL = 6'h12, OP_ROR = 6'h13, OP_ASR = 6'h14, OP_SWAP = 6'h15,
    OP_FSET = 6'h16, OP_FCLR = 6'h17, OP_BST = 6'h18, OP_BLD = 6'h19,
    OP_PLD = 6'h1A, OP_PST = 6'h1B, OP_DLD = 6'h1C, OP_DST = 6'h1D,
    OP_LDS = 6'h1E, OP_STS = 6'h1F, OP_LPM = 6'h20, OP_PUSH = 6'h21,
    OP_POP = 6'h22, OP_IN = 6'h23, OP_OUT = 6'h24, OP_RET = 6'h25,
    OP_INTERRUPT_EXIT = 6'h26, OP_SLEEP = 6'h27, OP_WDR = 6'h28, OP_BREAK = 6'h29,
    OP_CPI = 6'h3A, OP_LDI = 6'h3E
  } op_type;

  typedef enum logic [2:0] {
    PH1 = 3'b000, PH2 = 3'b001, PH3 = 3'b011, PH4 = 3'b010, PH5 = 3'b110
  } phase_type;

  typedef struct packed {
    op_type op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] b;
    logic [15:0] k;
    logic [2:0] s;
    logic [4:0] io;
    logic [1:0] ptr;
    logic [1:0] mode;
    logic zsel;
    logic [3:0] q;
    logic [7:0] imm;
  } ifield_type;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmem_req_type;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } io_wr_type;

endpackage

// [hdl/exec_core.sv]
// Functional notes
// - returns pop PC, 5 cycles; interrupt_exit sets I
// - equal_skip skips next instruction, one or two words, 1/2/3 cycles
// - compares subtract, set Z N V C H, 1 cycle
// - register bit skips test bit b, 1/2/3 cycles
// - I/O bit skips test bit b, 1/2/3 cycles
// - flag branches jump PC+k+1, 1/2 cycles
// - signed branches use N xor V
// - overflow and interrupt-flag branches, 1/2 cycles
// - I/O bit set/clear, no flags, 2 cycles
// - left shift and rotate, Z C N V, 1 cycle
// - right shift and rotate, Z C N V, 1 cycle
// - arithmetic right shift; nibble swap keeps flags
// - T flag bit store and load, 1 cycle
// - flag set/clear ops force one flag, 1 cycle
// - pointer reads with post-inc/pre-dec, 2 cycles
// - pointer writes with post-inc/pre-dec, 2 cycles
// - displaced access keeps pointer, 2 cycles
// - direct access uses address word, 2 cycles
// - program memory byte read via Z, 3 cycles
// - push and pop, 2 cycles, no flags
// - nop, sleep, watchdog restart: 1 cycle
// - break only signals the debug unit
`timescale 1ns/100ps
`default_nettype none
`include "core_cfg.svh"

module exec_core import core_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] pm_data,
  output logic [15:0] pm_addr,
  input wire logic [7:0] dm_rdata,
  output dmem_req_type dm_req,
  input wire logic [7:0] io_rdata,
  output logic [4:0] io_rd_addr,
  output io_wr_type io_wr,
  output logic [15:0] pc,
  output logic [15:0] stack_ptr,
  output logic [7:0] status_flags,
  output logic sleep_pulse,
  output logic wdr_pulse,
  output logic break_pulse
);

  // ==========================================================
  // Helpers
  function automatic ifield_type decode(input logic [15:0] w);
    ifield_type f;
    f.op = (w[`F_OP_HI:`F_OP_LO] > `OP_LAST) ? OP_NOP : op_type'(w[`F_OP_HI:`F_OP_LO]);
    f.rd = w[`F_RD_HI:`F_RD_LO];
    f.rr = w[`F_RR_HI:`F_RR_LO];
    f.b = (f.op == OP_SKIC || f.op == OP_SKIS || f.op == OP_IOSET || f.op == OP_IOCLR)
      ? w[`F_IOB_HI:`F_IOB_LO] : w[`F_S_HI:`F_S_LO];
    f.k = {{9{w[`F_K_HI]}}, w[`F_K_HI:`F_K_LO]};
    f.s = w[`F_S_HI:`F_S_LO];
    f.io = w[`F_IO_HI:`F_IO_LO];
    f.ptr = w[`F_PTR_HI:`F_PTR_LO];
    f.mode = w[`F_MODE_HI:`F_MODE_LO];
    f.zsel = w[`F_ZSEL];
    f.q = w[`F_Q_HI:`F_Q_LO];
    f.imm = w[`F_IMM_HI:`F_IMM_LO];
    if (w[`F_IMM_NIB_HI:`F_IMM_NIB_LO] == `NIB_CMP_IMM ||
        w[`F_IMM_NIB_HI:`F_IMM_NIB_LO] == `NIB_LOAD_IMM) begin
      f.op = (w[`F_IMM_NIB_HI:`F_IMM_NIB_LO] == `NIB_CMP_IMM) ? OP_CPI : OP_LDI;
      f.rd = {1'b1, w[`F_IMM_RD_HI:`F_IMM_RD_LO]};
    end
    return f;
  endfunction

  // Words that carry a second address word
  function automatic logic two_word(input logic [15:0] w);
    return w[`F_OP_HI:`F_OP_LO] == OP_LDS || w[`F_OP_HI:`F_OP_LO] == OP_STS;
  endfunction

  // Subtract a - b - cin: {H, V, N, C, result}
  function automatic logic [11:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
    logic [8:0] r;
    logic h;
    logic v;
    r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    return {h, v, r[7], r[8], r[7:0]};
  endfunction

  function automatic logic [3:0] ptr_pair(input logic [1:0] sel);
    return (sel == 2'h0) ? `PAIR_X : ((sel == 2'h1) ? `PAIR_Y : `PAIR_Z);
  endfunction

  // ==========================================================
  // State
  logic [7:0] rf [0:31];
  logic [15:0] pc_ff, nxt_pc, pm_addr_ff, nxt_pm_addr, ir_ff, nxt_ir, sp_ff, nxt_sp;
  logic [7:0] status_flags_reg_ff, nxt_status_flags_reg, tmp_ff, nxt_tmp;
  phase_type ph_ff, nxt_ph;
  dmem_req_type dm_ff, nxt_dm;
  io_wr_type iow_ff, nxt_iow;
  logic [4:0] iora_ff, nxt_iora;
  logic sleep_ff, nxt_sleep, wdr_ff, nxt_wdr, brk_ff, nxt_brk;
  logic w8_en, w16_en, adv, skip_hit, br_hit;
  logic [4:0] w8_idx;
  logic [3:0] w16_idx;
  logic [7:0] w8_val, rd_val, rr_val;
  logic [15:0] w16_val, pval, zval, target;
  ifield_type d;

  assign d = decode(ir_ff);
  assign rd_val = rf[d.rd];
  assign rr_val = rf[d.rr];
  assign pval = {rf[{ptr_pair(d.ptr), 1'b1}], rf[{ptr_pair(d.ptr), 1'b0}]};
  assign zval = {rf[{`PAIR_Z, 1'b1}], rf[{`PAIR_Z, 1'b0}]};
  assign target = pc_ff + 16'h0001 + d.k;

  // ==========================================================
  // Skip and branch conditions
  always_comb begin
    unique case (d.op)
      OP_EQSKIP: skip_hit = (rd_val == rr_val);
      OP_SKRC: skip_hit = ~rd_val[d.b];
      OP_SKRS: skip_hit = rd_val[d.b];
      OP_SKIC: skip_hit = ~io_rdata[d.b];
      OP_SKIS: skip_hit = io_rdata[d.b];
      default: skip_hit = 1'b0;
    endcase
    unique case (d.op)
      OP_BRS: br_hit = status_flags_reg_ff[d.s];
      OP_BRC: br_hit = ~status_flags_reg_ff[d.s];
      OP_BGE: br_hit = (status_flags_reg_ff[`FLAG_N] ^ status_flags_reg_ff[`FLAG_V]) == 1'b0;
      OP_BLT: br_hit = (status_flags_reg_ff[`FLAG_N] ^ status_flags_reg_ff[`FLAG_V]) == 1'b1;
      default: br_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Execution
  always_comb begin
    logic [11:0] sf;
    logic [7:0] sh;
    logic shc;
    sf = sub_flags(rd_val, (d.op == OP_CPI) ? d.imm : rr_val,
                   (d.op == OP_CPC) ? status_flags_reg_ff[`FLAG_C] : 1'b0);
    sh = 8'h00;
    shc = 1'b0;
    nxt_pc = pc_ff;
    nxt_pm_addr = pm_addr_ff;
    nxt_ir = ir_ff;
    nxt_sp = sp_ff;
    nxt_status_flags_reg = status_flags_reg_ff;
    nxt_tmp = tmp_ff;
    nxt_ph = PH1;
    nxt_dm = dm_ff;
    nxt_dm.we = 1'b0;
    nxt_dm.re = 1'b0;
    nxt_iow = iow_ff;
    nxt_iow.we = 1'b0;
    nxt_iora = iora_ff;
    nxt_sleep = 1'b0;
    nxt_wdr = 1'b0;
    nxt_brk = 1'b0;
    w8_en = 1'b0;
    w8_idx = d.rd;
    w8_val = 8'h00;
    w16_en = 1'b0;
    w16_idx = ptr_pair(d.ptr);
    w16_val = pval;
    adv = 1'b0;
    unique case (d.op)
      OP_NOP, OP_SLEEP, OP_WDR, OP_BREAK: begin
        adv = 1'b1;
        nxt_sleep = (d.op == OP_SLEEP);
        nxt_wdr = (d.op == OP_WDR);
        nxt_brk = (d.op == OP_BREAK);
      end
      OP_MOV, OP_LDI, OP_IN: begin
        adv = 1'b1;
        w8_en = 1'b1;
        w8_val = (d.op == OP_MOV) ? rr_val : ((d.op == OP_LDI) ? d.imm : io_rdata);
      end
      OP_PAIR: begin
        adv = 1'b1;
        w16_en = 1'b1;
        w16_idx = d.rd[4:1];
        w16_val = {rf[{d.rr[4:1], 1'b1}], rf[{d.rr[4:1], 1'b0}]};
      end
      OP_OUT: begin
        adv = 1'b1;
        nxt_iow = '{we: 1'b1, addr: d.io, wdata: rd_val};
      end
      OP_CP, OP_CPC, OP_CPI: begin
        adv = 1'b1;
        nxt_status_flags_reg[`FLAG_H] = sf[11];
        nxt_status_flags_reg[`FLAG_V] = sf[10];
        nxt_status_flags_reg[`FLAG_N] = sf[9];
        nxt_status_flags_reg[`FLAG_C] = sf[8];
        nxt_status_flags_reg[`FLAG_Z] = (sf[7:0] == 8'h00) &
          ((d.op == OP_CPC) ? status_flags_reg_ff[`FLAG_Z] : 1'b1);
      end
      OP_EQSKIP, OP_SKRC, OP_SKRS, OP_SKIC, OP_SKIS: begin
        if (ph_ff == PH1 && skip_hit) begin
          nxt_pm_addr = pm_addr_ff + (two_word(pm_data) ? 16'h0002 : 16'h0001);
          nxt_ph = two_word(pm_data) ? PH2 : PH3;
        end else if (ph_ff == PH2) begin
          nxt_ph = PH3;
        end else begin
          adv = 1'b1;
        end
      end
      OP_BRS, OP_BRC, OP_BGE, OP_BLT: begin
        if (ph_ff == PH1 && br_hit) begin
          nxt_pm_addr = target;
          nxt_ph = PH2;
        end else begin
          adv = 1'b1;
        end
      end
      OP_IOSET, OP_IOCLR: begin
        if (ph_ff == PH1) begin
          nxt_iow.we = 1'b1;
          nxt_iow.addr = d.io;
          nxt_iow.wdata = io_rdata;
          nxt_iow.wdata[d.b] = (d.op == OP_IOSET);
          nxt_ph = PH2;
        end else begin
          adv = 1'b1;
        end
      end
      OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
        adv = 1'b1;
        unique case (d.op)
          OP_LSL: {shc, sh} = {rd_val, 1'b0};
          OP_ROL: {shc, sh} = {rd_val, status_flags_reg_ff[`FLAG_C]};
          OP_LSR: {sh, shc} = {1'b0, rd_val};
          OP_ROR: {sh, shc} = {status_flags_reg_ff[`FLAG_C], rd_val};
          default: {sh, shc} = {rd_val[7], rd_val};
        endcase
        w8_en = 1'b1;
        w8_val = sh;
        nxt_status_flags_reg[`FLAG_C] = shc;
        nxt_status_flags_reg[`FLAG_Z] = (sh == 8'h00);
        nxt_status_flags_reg[`FLAG_N] = sh[7];
        nxt_status_flags_reg[`FLAG_V] = sh[7] ^ shc;
      end
      OP_SWAP: begin
        adv = 1'b1;
        w8_en = 1'b1;
        w8_val = {rd_val[3:0], rd_val[7:4]};
      end
      OP_FSET, OP_FCLR: begin
        adv = 1'b1;
        nxt_status_flags_reg[d.s] = (d.op == OP_FSET);
      end
      OP_BST: begin
        adv = 1'b1;
        nxt_status_flags_reg[`FLAG_T] = rd_val[d.b];
      end
      OP_BLD: begin
        adv = 1'b1;
        w8_en = 1'b1;
        w8_val = rd_val;
        w8_val[d.b] = status_flags_reg_ff[`FLAG_T];
      end
      OP_PLD, OP_PST, OP_DLD, OP_DST, OP_LDS, OP_STS, OP_PUSH, OP_POP: begin
        if (ph_ff == PH1) begin
          nxt_ph = PH2;
          nxt_dm.wdata = rd_val;
          nxt_dm.we = (d.op == OP_PST || d.op == OP_DST || d.op == OP_STS ||
                       d.op == OP_PUSH);
          nxt_dm.re = ~nxt_dm.we;
          unique case (d.op)
            OP_PLD, OP_PST: begin
              nxt_dm.addr = (d.mode == `MODE_PRE_DEC) ? pval - 16'h0001 : pval;
              w16_en = (d.mode != `MODE_PLAIN);
              w16_val = (d.mode == `MODE_PRE_DEC) ? pval - 16'h0001 : pval + 16'h0001;
            end
            OP_DLD, OP_DST: begin
              w16_idx = d.zsel ? `PAIR_Z : `PAIR_Y;
              nxt_dm.addr = {rf[{w16_idx, 1'b1}], rf[{w16_idx, 1'b0}]} +
                            {12'h000, d.q};
            end
            OP_LDS, OP_STS: begin
              nxt_dm.addr = pm_data;
              nxt_pm_addr = pm_addr_ff + 16'h0001;
            end
            OP_PUSH: begin
              nxt_dm.addr = sp_ff;
              nxt_sp = sp_ff - 16'h0001;
            end
            default: begin
              nxt_dm.addr = sp_ff + 16'h0001;
              nxt_sp = sp_ff + 16'h0001;
            end
          endcase
        end else begin
          adv = 1'b1;
          w8_en = dm_ff.re;
          w8_val = dm_rdata;
        end
      end
      OP_LPM: begin
        unique case (ph_ff)
          PH1: begin
            nxt_pm_addr = {1'b0, zval[15:1]};
            nxt_tmp = {7'h00, zval[0]};
            w16_idx = `PAIR_Z;
            w16_en = d.mode[0];
            w16_val = zval + 16'h0001;
            nxt_ph = PH2;
          end
          PH2: begin
            w8_en = 1'b1;
            w8_idx = d.mode[1] ? 5'h00 : d.rd;
            w8_val = tmp_ff[0] ? pm_data[15:8] : pm_data[7:0];
            nxt_pm_addr = pc_ff + 16'h0001;
            nxt_ph = PH3;
          end
          default: adv = 1'b1;
        endcase
      end
      OP_RET, OP_INTERRUPT_EXIT: begin
        unique case (ph_ff)
          PH1, PH2: begin
            nxt_dm.re = 1'b1;
            nxt_dm.addr = sp_ff + 16'h0001;
            nxt_sp = sp_ff + 16'h0001;
            nxt_tmp = dm_rdata;
            nxt_ph = (ph_ff == PH1) ? PH2 : PH3;
          end
          PH3: begin
            nxt_pm_addr = {tmp_ff, dm_rdata};
            nxt_ph = PH4;
          end
          PH4: nxt_ph = PH5;
          default: begin
            adv = 1'b1;
            if (d.op == OP_INTERRUPT_EXIT) begin
              nxt_status_flags_reg[`FLAG_I] = 1'b1;
            end
          end
        endcase
      end
      default: adv = 1'b1;
    endcase
    if (adv) begin
      nxt_ir = pm_data;
      nxt_pc = pm_addr_ff;
      nxt_pm_addr = pm_addr_ff + 16'h0001;
      nxt_iora = pm_data[`F_IO_HI:`F_IO_LO];
      nxt_ph = PH1;
    end
  end

  always_ff @(posedge mclk) begin
    if (w16_en) begin
      rf[{w16_idx, 1'b1}] <= w16_val[15:8];
      rf[{w16_idx, 1'b0}] <= w16_val[7:0];
    end
    if (w8_en) begin
      rf[w8_idx] <= w8_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_ff <= `PC_RESET;
      pm_addr_ff <= `PC_RESET;
      ir_ff <= `IR_RESET;
      sp_ff <= `SP_RESET;
      status_flags_reg_ff <= `STATUS_FLAGS_REG_RESET;
      tmp_ff <= 8'h00;
      ph_ff <= PH1;
      dm_ff <= '0;
      iow_ff <= '0;
      iora_ff <= 5'h00;
      sleep_ff <= 1'b0;
      wdr_ff <= 1'b0;
      brk_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      pm_addr_ff <= nxt_pm_addr;
      ir_ff <= nxt_ir;
      sp_ff <= nxt_sp;
      status_flags_reg_ff <= nxt_status_flags_reg;
      tmp_ff <= nxt_tmp;
      ph_ff <= nxt_ph;
      dm_ff <= nxt_dm;
      iow_ff <= nxt_iow;
      iora_ff <= nxt_iora;
      sleep_ff <= nxt_sleep;
      wdr_ff <= nxt_wdr;
      brk_ff <= nxt_brk;
    end
  end

  assign pm_addr = pm_addr_ff;
  assign dm_req = dm_ff;
  assign io_rd_addr = iora_ff;
  assign io_wr = iow_ff;
  assign pc = pc_ff;
  assign stack_ptr = sp_ff;
  assign status_flags = status_flags_reg_ff;
  assign sleep_pulse = sleep_ff;
  assign wdr_pulse = wdr_ff;
  assign break_pulse = brk_ff;

endmodule // exec_core

`default_nettype wire

// [verif/exec_core_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module exec_core_asserts import core_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] pm_data,
  input wire dmem_req_type dm_req,
  input wire io_wr_type io_wr,
  input wire logic [15:0] pc,
  input wire logic [15:0] stack_ptr,
  input wire logic [7:0] status_flags
);
  // ==========================================
  // Instruction start tracking
  logic [15:0] prev_pc_ff;
  logic [15:0] ir_ff;
  logic [15:0] cur_ff;
  logic [15:0] nxt_cur;
  logic [15:0] tgt;
  logic start;
  logic [5:0] op;

  // A new pc marks the first cycle of an instruction
  always_comb begin
    start = pc != prev_pc_ff;
    op = ir_ff[15:10];
    tgt = pc + {{9{ir_ff[9]}}, ir_ff[9:3]} + 16'h0001;
    nxt_cur = start ? ir_ff : cur_ff;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_pc_ff <= '0;
      ir_ff <= '0;
      cur_ff <= '0;
    end else begin
      prev_pc_ff <= pc;
      ir_ff <= pm_data;
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence five_on;
    !start [*4] ##1 start;
  endsequence

  sequence two_on;
    !start ##1 start;
  endsequence

  a_interrupt_exit_five: assert property (start && op == OP_INTERRUPT_EXIT |=> five_on ##0 status_flags[7])
    else $error("interrupt exit timing");
  a_ret_pops: assert property (start && op == OP_RET |=>
      five_on ##0 stack_ptr == $past(stack_ptr, 5) + 16'h0002)
    else $error("subroutine exit timing");
  a_flag_force: assert property (start && (op == OP_FSET || op == OP_FCLR) |=>
      start && status_flags[cur_ff[2:0]] == (cur_ff[15:10] == OP_FSET))
    else $error("flag op result");
  a_brs_taken: assert property (start && op == OP_BRS && status_flags[ir_ff[2:0]] |=>
      two_on ##0 pc == $past(tgt, 2))
    else $error("taken branch");
  a_brs_fall: assert property (start && op == OP_BRS && !status_flags[ir_ff[2:0]] |=>
      start && pc == $past(pc) + 16'h0001)
    else $error("untaken branch");
  a_signed_ge: assert property (start && op == OP_BGE && !(status_flags[2] ^ status_flags[3]) |=>
      two_on ##0 pc == $past(tgt, 2))
    else $error("signed branch");
  a_store_strobe: assert property (start && op == OP_PST |=>
      dm_req.we ##1 (start && !dm_req.we))
    else $error("store strobe");
  a_io_bit: assert property (start && (op == OP_IOSET || op == OP_IOCLR) |=>
      (io_wr.we && io_wr.addr == cur_ff[4:0]
      && io_wr.wdata[cur_ff[7:5]] == (cur_ff[15:10] == OP_IOSET)) ##1 start)
    else $error("io bit write");
endmodule // exec_core_asserts

bind exec_core exec_core_asserts i_exec_core_asserts (
  .mclk(mclk), .rst_n(rst_n), .pm_data(pm_data), .dm_req(dm_req), .io_wr(io_wr),
  .pc(pc), .stack_ptr(stack_ptr), .status_flags(status_flags)
);

`default_nettype wire

// [verif/mem_model.sv]
`timescale 1ns/100ps
`default_nettype none

module mem_model import core_pkg::*; (
  input wire logic mclk,
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  input wire dmem_req_type dm_req,
  output logic [7:0] dm_rdata,
  input wire logic [4:0] io_rd_addr,
  input wire io_wr_type io_wr,
  output logic [7:0] io_rdata
);
  // ==========================================
  // Program, data and I/O stores
  logic [15:0] rom_ff [256];
  logic [7:0] ram_ff [4096];
  logic [7:0] io_ff [32];
  logic [7:0] last_ff = 8'h00;

  assign pm_data = rom_ff[pm_addr[7:0]];
  // Unselected data bus shows a changed pattern, not stale data
  assign dm_rdata = dm_req.re ? ram_ff[dm_req.addr[11:0]] : ~last_ff;
  assign io_rdata = io_ff[io_rd_addr];

  always @(posedge mclk) begin
    if (dm_req.re) last_ff <= ram_ff[dm_req.addr[11:0]];
    if (dm_req.we) ram_ff[dm_req.addr[11:0]] <= dm_req.wdata;
    if (io_wr.we) io_ff[io_wr.addr] <= io_wr.wdata;
  end
endmodule // mem_model

`default_nettype wire

// [verif/exec_core_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module exec_core_tb import core_pkg::*; ;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] pm_data, pm_addr, pc, stack_ptr;
  logic [7:0] dm_rdata, io_rdata, status_flags;
  logic [4:0] io_rd_addr;
  dmem_req_type dm_req;
  io_wr_type io_wr;
  int failures = 0;
  int compares = 0;
  int cyc;
  int pulses;
  logic slp, wdg, brk;
  int first_at [256];
  logic [7:0] fl_at [256];
  logic [23:0] wq [$];
  logic [12:0] iq [$];
  localparam logic [15:0] nop_w = 16'h0000;

  always #2.5 mclk = ~mclk;

  exec_core i_exec_core (.mclk(mclk), .rst_n(rst_n), .pm_data(pm_data), .pm_addr(pm_addr),
    .dm_rdata(dm_rdata), .dm_req(dm_req), .io_rdata(io_rdata), .io_rd_addr(io_rd_addr),
    .io_wr(io_wr), .pc(pc), .stack_ptr(stack_ptr), .status_flags(status_flags),
    .sleep_pulse(slp), .wdr_pulse(wdg), .break_pulse(brk));
  mem_model i_mem_model (.mclk(mclk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .io_rd_addr(io_rd_addr), .io_wr(io_wr), .io_rdata(io_rdata));

  // ==========================================
  // Trace: first cycle at each pc, flags then, writes
  always @(negedge mclk) begin
    if (rst_n) begin
      if (first_at[pc[7:0]] < 0) begin
        first_at[pc[7:0]] = cyc;
        fl_at[pc[7:0]] = status_flags;
      end
      if (dm_req.we === 1'b1) wq.push_back({dm_req.addr, dm_req.wdata});
      if (io_wr.we === 1'b1) iq.push_back({io_wr.addr, io_wr.wdata});
      if ((slp | wdg | brk) === 1'b1) pulses++;
      cyc++;
    end
  end

  function automatic logic [15:0] w(op_type op, logic [4:0] a, logic [4:0] b);
    return {op, a, b};
  endfunction
  function automatic logic [15:0] br(op_type op, logic [6:0] k, logic [2:0] s);
    return {op, k, s};
  endfunction
  function automatic logic [15:0] immediate_load(logic [3:0] r, logic [7:0] k);
    return {4'hF, r, k};
  endfunction

  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic dur(int a, int b, int n);
    chk("cycles", 24'(first_at[b] - first_at[a]), 24'(n));
  endtask
  task automatic fl(int a, logic [7:0] e);
    chk("flags", 24'(fl_at[a]), 24'(e));
  endtask
  task automatic wr(int i, logic [23:0] e);
    chk("write", wq[i], e);
  endtask

  task automatic run(input logic [15:0] p [$], input int n);
    foreach (i_mem_model.rom_ff[i]) i_mem_model.rom_ff[i] = nop_w;
    foreach (p[i]) i_mem_model.rom_ff[i] = p[i];
    rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("pc", 24'(pc), 24'h00_0000);
    chk("stack", 24'(stack_ptr), 24'h00_08FF);
    chk("flags", 24'(status_flags), 24'h00_0000);
    foreach (first_at[i]) first_at[i] = -1;
    wq.delete();
    iq.delete();
    cyc = 0;
    pulses = 0;
    rst_n <= 1'b1;
    repeat (n) @(posedge mclk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_cmp;
    run('{nop_w, immediate_load(0, 8'h05), 16'hE005, 16'hE006, w(OP_FSET, 0, 6), w(OP_FCLR, 0, 0),
      w(OP_SLEEP, 0, 0), w(OP_WDR, 0, 0), nop_w, w(OP_BREAK, 0, 0), nop_w}, 20);
    fl(3, 8'h02);
    fl(4, 8'h25);
    dur(2, 4, 2);
    fl(5, 8'h65);
    fl(6, 8'h64);
    dur(6, 8, 2);
    fl(8, 8'h64);
    chk("pulses", 24'(pulses), 24'h00_0003);
    $display("compare test done");
  endtask

  task automatic t_shift;
    run('{nop_w, immediate_load(10, 8'h20), immediate_load(11, 8'h00), immediate_load(0, 8'h81), w(OP_LSL, 16, 0),
      w(OP_PST, 16, 1), w(OP_ROR, 16, 0), w(OP_PST, 16, 1), w(OP_ASR, 16, 0),
      w(OP_PST, 16, 1), w(OP_SWAP, 16, 0), w(OP_PST, 16, 1), w(OP_LSR, 16, 0),
      w(OP_ROL, 16, 0), w(OP_PST, 16, 1), w(OP_BST, 16, 2), w(OP_BLD, 16, 0),
      w(OP_PST, 16, 1), nop_w}, 40);
    fl(5, 8'h09);
    dur(4, 5, 1);
    fl(7, 8'h0C);
    fl(9, 8'h05);
    fl(11, 8'h05);
    fl(14, 8'h00);
    fl(16, 8'h40);
    wr(0, 24'h00_2002);
    wr(1, 24'h00_2181);
    wr(2, 24'h00_22C0);
    wr(3, 24'h00_230C);
    wr(4, 24'h00_240C);
    wr(5, 24'h00_250D);
    $display("shift test done");
  endtask

  task automatic t_mem;
    i_mem_model.io_ff[5] = 8'h81;
    run('{nop_w, immediate_load(10, 8'h10), immediate_load(11, 8'h00), immediate_load(0, 8'hA5), immediate_load(1, 8'h3C),
      w(OP_PST, 16, 1), w(OP_PST, 17, 2), w(OP_PLD, 18, 1), w(OP_PST, 18, 0),
      w(OP_IOSET, 3, 5), w(OP_IOCLR, 0, 5), w(OP_PUSH, 16, 16), w(OP_POP, 19, 19),
      w(OP_PST, 19, 0), nop_w}, 40);
    wr(0, 24'h00_10A5);
    wr(1, 24'h00_103C);
    wr(2, 24'h00_113C);
    dur(5, 7, 4);
    dur(7, 9, 4);
    chk("io", 24'(iq[0]), 24'h00_0589);
    chk("io", 24'(iq[1]), 24'h00_0588);
    dur(9, 11, 4);
    wr(3, 24'h08_FFA5);
    wr(4, 24'h00_11A5);
    dur(11, 13, 4);
    chk("stack", 24'(stack_ptr), 24'h00_08FF);
    $display("memory test done");
  endtask

  task automatic t_branch;
    run('{nop_w, w(OP_FSET, 0, 0), br(OP_BRS, 3, 0), nop_w, nop_w, nop_w, br(OP_BRS, 3, 1),
      br(OP_BGE, 1, 0), nop_w, br(OP_BLT, 1, 0), br(OP_BRC, 1, 3), nop_w, br(OP_BRC, 1, 7),
      nop_w, w(OP_FSET, 0, 2), br(OP_BLT, 1, 0), nop_w, br(OP_BRS, 1, 7), nop_w}, 30);
    dur(2, 6, 2);
    chk("skipped", 24'(first_at[3]), 24'hFF_FFFF);
    dur(6, 7, 1);
    dur(7, 9, 2);
    dur(9, 10, 1);
    dur(10, 12, 2);
    dur(12, 14, 2);
    dur(15, 17, 2);
    dur(17, 18, 1);
    $display("branch test done");
  endtask

  task automatic t_skip;
    i_mem_model.io_ff[2] = 8'h01;
    run('{nop_w, immediate_load(0, 8'h07), immediate_load(1, 8'h07), w(OP_EQSKIP, 16, 17), immediate_load(0, 8'h00),
      w(OP_SKRC, 16, 3), w(OP_STS, 16, 16), 16'h0040, w(OP_SKIC, 0, 2), w(OP_SKIS, 0, 2),
      nop_w, w(OP_SKRS, 16, 3), nop_w}, 25);
    dur(3, 5, 2);
    dur(5, 8, 3);
    chk("writes", 24'(wq.size()), 24'h00_0000);
    dur(8, 9, 1);
    dur(9, 11, 2);
    dur(11, 12, 1);
    $display("skip test done");
  endtask

  task automatic t_ret;
    i_mem_model.ram_ff[12'h900] = 8'h00;
    i_mem_model.ram_ff[12'h901] = 8'h03;
    i_mem_model.ram_ff[12'h902] = 8'h00;
    i_mem_model.ram_ff[12'h903] = 8'h05;
    run('{nop_w, w(OP_INTERRUPT_EXIT, 0, 0), nop_w, w(OP_RET, 0, 0), nop_w, nop_w}, 20);
    dur(1, 3, 5);
    fl(3, 8'h80);
    dur(3, 5, 5);
    fl(5, 8'h80);
    chk("stack", 24'(stack_ptr), 24'h00_0903);
    $display("return test done");
  endtask

  task automatic t_xfer;
    run('{nop_w, immediate_load(10, 8'h60), immediate_load(11, 8'h00), immediate_load(12, 8'h30), immediate_load(13, 8'h00),
      immediate_load(14, 8'h03), immediate_load(15, 8'h00), immediate_load(0, 8'h5A), w(OP_DST, 16, 2), w(OP_DLD, 17, 2),
      w(OP_STS, 17, 0), 16'h0040, w(OP_LDS, 18, 0), 16'h0032, w(OP_LPM, 19, 1),
      w(OP_MOV, 20, 17), w(OP_PAIR, 22, 18), w(OP_IN, 21, 2), w(OP_OUT, 23, 7),
      w(OP_PST, 21, 1), w(OP_PST, 23, 1), w(OP_PST, 30, 1), w(OP_PST, 20, 1),
      w(OP_PST, 22, 1), nop_w}, 45);
    wr(0, 24'h00_325A);
    wr(1, 24'h00_405A);
    wr(2, 24'h00_6001);
    wr(3, 24'h00_61FA);
    wr(4, 24'h00_6204);
    wr(5, 24'h00_635A);
    wr(6, 24'h00_645A);
    chk("io", 24'(iq[0]), 24'h00_07FA);
    dur(8, 9, 2);
    dur(10, 12, 2);
    dur(12, 14, 2);
    dur(14, 15, 3);
    dur(15, 18, 3);
    fl(23, 8'h00);
    $display("transfer test done");
  endtask

  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    t_cmp();
    t_shift();
    t_mem();
    t_branch();
    t_skip();
    t_ret();
    t_xfer();
    wrap_up();
  end
endmodule // exec_core_tb

`default_nettype wire
